// [core/tmr8_core.v]
`include "tmr8_regs.vh"

module tmr8_core #(
    parameter ADR_W = 8
) (
    input wire clock,
    input wire nrst,
    input wire ce,
    input wire wb_cyc,
    input wire wb_stb,
    input wire wb_we,
    input wire [ADR_W-1:0] wb_adr,
    input wire [3:0] wb_sel,
    input wire [31:0] wb_wdata,
    output reg [31:0] wb_rdata,
    output reg wb_ack,
    input wire global_irq_enable,
    input wire overflow_irq_taken,
    input wire compare_irq_taken,
    input wire external_count_pin,
    output reg overflow_irq,
    output reg compare_irq,
    output reg compare_output_pin,
    output reg compare_output_oe
);

// ================================================
// state
reg [2:0] clock_select_field_reg;
reg [1:0] waveform_mode_bits_reg;
reg [1:0] compare_output_mode_bits_reg;
reg [7:0] timer_count_value_reg;
reg [7:0] compare_value_reg;
reg [7:0] compare_buffer_reg;
reg overflow_flag_reg;
reg compare_match_flag_reg;
reg overflow_irq_enable_reg;
reg compare_irq_enable_reg;
reg port_data_reg;
reg compare_pin_direction_reg;
reg compare_output_reg;
reg count_up_reg;
reg block_reg;
reg ext_sync1_reg;
reg ext_sync2_reg;

reg [7:0] count_next;
reg compare_output_next;
reg count_up_next;
reg [31:0] rdata_next;

wire timer_tick;

// ================================================
// external pin synchroniser and tick source
always @(posedge clock or negedge nrst)
begin
    if (!nrst)
    begin
        ext_sync1_reg <= 1'b0;
        ext_sync2_reg <= 1'b0;
    end
    else if (ce)
    begin
        ext_sync1_reg <= external_count_pin;
        ext_sync2_reg <= ext_sync1_reg;
    end
end

tmr8_tick_gen #(
    .PRE_W(10)
) u_tick (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .clock_select_field(clock_select_field_reg),
    .ext_level(ext_sync2_reg),
    .timer_tick(timer_tick)
);

// ================================================
// bus decode
wire bus_req = wb_cyc & wb_stb;
wire wr_fire = bus_req & wb_we & wb_ack & wb_sel[0];
wire [7:0] wbyte = wb_wdata[7:0];
wire wr_ctrl = wr_fire && (wb_adr == `TMR8_ADR_CTRL);
wire wr_count = wr_fire && (wb_adr == `TMR8_ADR_COUNT);
wire wr_compare = wr_fire && (wb_adr == `TMR8_ADR_COMPARE);
wire wr_flags = wr_fire && (wb_adr == `TMR8_ADR_FLAGS);
wire wr_mask = wr_fire && (wb_adr == `TMR8_ADR_MASK);
wire wr_port = wr_fire && (wb_adr == `TMR8_ADR_PORT);

// ================================================
// counter unit
wire [1:0] mode = waveform_mode_bits_reg;
wire [1:0] com = compare_output_mode_bits_reg;
wire pwm_mode = (mode == `TMR8_MODE_PHASE) || (mode == `TMR8_MODE_FAST);
wire at_bottom = timer_count_value_reg == `TMR8_BOTTOM;
wire at_max = timer_count_value_reg == `TMR8_MAX;
wire [7:0] top_value = (mode == `TMR8_MODE_CTC) ? compare_value_reg : `TMR8_MAX;
wire at_top = timer_count_value_reg == top_value;
wire match = timer_count_value_reg == compare_value_reg;
wire match_event = timer_tick & match & ~block_reg;
wire force_event = wr_ctrl & wbyte[`TMR8_FOC_BIT] & ~pwm_mode;
wire [7:0] count_inc = timer_count_value_reg + 8'h01;
wire [7:0] count_dec = timer_count_value_reg - 8'h01;

always @*
begin
    count_next = timer_count_value_reg;
    count_up_next = count_up_reg;
    case (mode)
        `TMR8_MODE_NORMAL: count_next = count_inc;
        `TMR8_MODE_CTC: count_next = at_top ? `TMR8_BOTTOM : count_inc;
        `TMR8_MODE_FAST: count_next = at_top ? `TMR8_BOTTOM : count_inc;
        `TMR8_MODE_PHASE:
        begin
            if (count_up_reg)
            begin
                count_next = at_max ? count_dec : count_inc;
                count_up_next = ~at_max;
            end
            else
            begin
                count_next = at_bottom ? count_inc : count_dec;
                count_up_next = at_bottom;
            end
        end
        default: count_next = count_inc;
    endcase
end

// overflow: on the max-to-bottom tick, or at bottom in the dual-slope mode
wire overflow_event = timer_tick &
    ((mode == `TMR8_MODE_PHASE) ? (at_bottom & ~count_up_reg) : at_max);

// ================================================
// compare output state; bottom action beats match so a compare value of max gives a steady output
always @*
begin
    compare_output_next = compare_output_reg;
    if (!pwm_mode)
    begin
        if (match_event || force_event)
        begin
            case (com)
                `TMR8_COM_TOGGLE: compare_output_next = ~compare_output_reg;
                `TMR8_COM_CLEAR: compare_output_next = 1'b0;
                `TMR8_COM_SET: compare_output_next = 1'b1;
                default: compare_output_next = compare_output_reg;
            endcase
        end
    end
    else if (mode == `TMR8_MODE_FAST)
    begin
        if (timer_tick && at_max && com == `TMR8_COM_CLEAR)
            compare_output_next = 1'b1;
        else if (timer_tick && at_max && com == `TMR8_COM_SET)
            compare_output_next = 1'b0;
        else if (match_event)
        begin
            case (com)
                `TMR8_COM_TOGGLE: compare_output_next = ~compare_output_reg;
                `TMR8_COM_CLEAR: compare_output_next = 1'b0;
                `TMR8_COM_SET: compare_output_next = 1'b1;
                default: compare_output_next = compare_output_reg;
            endcase
        end
    end
    else if (match_event)
    begin
        case (com)
            `TMR8_COM_CLEAR: compare_output_next = ~count_up_reg;
            `TMR8_COM_SET: compare_output_next = count_up_reg;
            default: compare_output_next = compare_output_reg;
        endcase
    end
end

// ================================================
// read mux; reserved bits read as zero
always @*
begin
    rdata_next = 32'h00000000;
    case (wb_adr)
        `TMR8_ADR_CTRL:
            rdata_next[6:0] = {com, mode, clock_select_field_reg};
        `TMR8_ADR_COUNT:
            rdata_next[7:0] = timer_count_value_reg;
        `TMR8_ADR_COMPARE:
            rdata_next[7:0] = pwm_mode ? compare_buffer_reg : compare_value_reg;
        `TMR8_ADR_FLAGS:
        begin
            rdata_next[`TMR8_OVF_BIT] = overflow_flag_reg;
            rdata_next[`TMR8_CMP_BIT] = compare_match_flag_reg;
        end
        `TMR8_ADR_MASK:
        begin
            rdata_next[`TMR8_OVF_BIT] = overflow_irq_enable_reg;
            rdata_next[`TMR8_CMP_BIT] = compare_irq_enable_reg;
        end
        `TMR8_ADR_PORT:
        begin
            rdata_next[`TMR8_PORT_DATA_BIT] = port_data_reg;
            rdata_next[`TMR8_PORT_DIR_BIT] = compare_pin_direction_reg;
        end
        `TMR8_ADR_STATUS:
            rdata_next[3:0] = {count_up_reg, match, at_max, at_bottom};
        default:
            rdata_next = 32'h00000000;
    endcase
end

// ================================================
// bus answer: ack one cycle after the request, write lands at the ack edge
always @(posedge clock or negedge nrst)
begin
    if (!nrst)
    begin
        wb_ack <= 1'b0;
        wb_rdata <= 32'h00000000;
    end
    else if (ce)
    begin
        wb_ack <= bus_req & ~wb_ack;
        if (bus_req && !wb_ack)
            wb_rdata <= rdata_next;
    end
end

// ================================================
// configuration, counter and compare registers
always @(posedge clock or negedge nrst)
begin
    if (!nrst)
    begin
        clock_select_field_reg <= `TMR8_CS_STOP;
        waveform_mode_bits_reg <= `TMR8_MODE_NORMAL;
        compare_output_mode_bits_reg <= `TMR8_COM_OFF;
        timer_count_value_reg <= `TMR8_RST_BYTE;
        compare_value_reg <= `TMR8_RST_BYTE;
        compare_buffer_reg <= `TMR8_RST_BYTE;
        overflow_irq_enable_reg <= 1'b0;
        compare_irq_enable_reg <= 1'b0;
        port_data_reg <= 1'b0;
        compare_pin_direction_reg <= 1'b0;
        count_up_reg <= 1'b1;
        block_reg <= 1'b0;
        compare_output_reg <= 1'b0;
    end
    else if (ce)
    begin
        if (wr_ctrl)
        begin
            clock_select_field_reg <= wbyte[`TMR8_CS_MSB:`TMR8_CS_LSB];
            waveform_mode_bits_reg <= wbyte[`TMR8_WGM_MSB:`TMR8_WGM_LSB];
            compare_output_mode_bits_reg <= wbyte[`TMR8_COM_MSB:`TMR8_COM_LSB];
        end
        if (wr_mask)
        begin
            overflow_irq_enable_reg <= wbyte[`TMR8_OVF_BIT];
            compare_irq_enable_reg <= wbyte[`TMR8_CMP_BIT];
        end
        if (wr_port)
        begin
            port_data_reg <= wbyte[`TMR8_PORT_DATA_BIT];
            compare_pin_direction_reg <= wbyte[`TMR8_PORT_DIR_BIT];
        end
        if (wr_count)
            timer_count_value_reg <= wbyte;
        else if (timer_tick)
            timer_count_value_reg <= count_next;
        if (timer_tick)
            count_up_reg <= (mode == `TMR8_MODE_PHASE) ? count_up_next : 1'b1;
        if (wr_count)
            block_reg <= 1'b1;
        else if (timer_tick)
            block_reg <= 1'b0;
        if (wr_compare)
        begin
            compare_buffer_reg <= wbyte;
            if (!pwm_mode)
                compare_value_reg <= wbyte;
        end
        // fast mode reloads at the max-to-bottom tick, dual-slope at max
        if (pwm_mode && timer_tick && at_max)
            compare_value_reg <= compare_buffer_reg;
        compare_output_reg <= compare_output_next;
    end
end

// ================================================
// flags: a set in the same cycle as a clear wins
wire ovf_clear = (wr_flags & wbyte[`TMR8_OVF_BIT]) | overflow_irq_taken;
wire cmp_clear = (wr_flags & wbyte[`TMR8_CMP_BIT]) | compare_irq_taken;

always @(posedge clock or negedge nrst)
begin
    if (!nrst)
    begin
        overflow_flag_reg <= 1'b0;
        compare_match_flag_reg <= 1'b0;
        overflow_irq <= 1'b0;
        compare_irq <= 1'b0;
        compare_output_pin <= 1'b0;
        compare_output_oe <= 1'b0;
    end
    else if (ce)
    begin
        overflow_flag_reg <= overflow_event | (overflow_flag_reg & ~ovf_clear);
        compare_match_flag_reg <= match_event | (compare_match_flag_reg & ~cmp_clear);
        overflow_irq <= overflow_flag_reg & overflow_irq_enable_reg & global_irq_enable;
        compare_irq <= compare_match_flag_reg & compare_irq_enable_reg
            & global_irq_enable;
        // override applies in every mode so the state can be preset with the pin still input
        compare_output_pin <= (com != `TMR8_COM_OFF) ?
            compare_output_next : port_data_reg;
        compare_output_oe <= compare_pin_direction_reg;
    end
end

endmodule // tmr8_core

// [core/tmr8_regs.vh]
`ifndef TMR8_REGS_VH
`define TMR8_REGS_VH

// ================================================
// register offsets (byte addresses, one word each)
`define TMR8_ADR_CTRL 8'h00
`define TMR8_ADR_COUNT 8'h04
`define TMR8_ADR_COMPARE 8'h08
`define TMR8_ADR_FLAGS 8'h0c
`define TMR8_ADR_MASK 8'h10
`define TMR8_ADR_PORT 8'h14
`define TMR8_ADR_STATUS 8'h18

// ================================================
// control register fields
`define TMR8_CS_LSB 0
`define TMR8_CS_MSB 2
`define TMR8_WGM_LSB 3
`define TMR8_WGM_MSB 4
`define TMR8_COM_LSB 5
`define TMR8_COM_MSB 6
`define TMR8_FOC_BIT 7

// flag and mask register bits
`define TMR8_OVF_BIT 0
`define TMR8_CMP_BIT 1

// port register bits
`define TMR8_PORT_DATA_BIT 0
`define TMR8_PORT_DIR_BIT 1

// ================================================
// waveform modes
`define TMR8_MODE_NORMAL 2'h0
`define TMR8_MODE_PHASE 2'h1
`define TMR8_MODE_CTC 2'h2
`define TMR8_MODE_FAST 2'h3

// compare output modes
`define TMR8_COM_OFF 2'h0
`define TMR8_COM_TOGGLE 2'h1
`define TMR8_COM_CLEAR 2'h2
`define TMR8_COM_SET 2'h3

// clock select codes
`define TMR8_CS_STOP 3'h0
`define TMR8_CS_DIV1 3'h1
`define TMR8_CS_DIV8 3'h2
`define TMR8_CS_DIV64 3'h3
`define TMR8_CS_DIV256 3'h4
`define TMR8_CS_DIV1024 3'h5
`define TMR8_CS_EXT_FALL 3'h6
`define TMR8_CS_EXT_RISE 3'h7

// ================================================
// prescaler tap masks (divisor minus one)
`define TMR8_MASK_DIV8 10'h007
`define TMR8_MASK_DIV64 10'h03f
`define TMR8_MASK_DIV256 10'h0ff
`define TMR8_MASK_DIV1024 10'h3ff

// ================================================
// counter extremes and reset values
`define TMR8_BOTTOM 8'h00
`define TMR8_MAX 8'hff
`define TMR8_RST_BYTE 8'h00

`endif

// [core/tmr8_tick_gen.v]
`include "tmr8_regs.vh"

// ================================================
// free running prescaler and tick source selection
module tmr8_tick_gen #(
    parameter PRE_W = 10
) (
    input wire clock,
    input wire nrst,
    input wire ce,
    input wire [2:0] clock_select_field,
    input wire ext_level,
    output reg timer_tick
);

reg [PRE_W-1:0] pre_reg;
reg ext_prev_reg;

// prescaler is never cleared by the select, so the first prescaled tick may come anywhere from 0 to n-1 cycles after the select
always @(posedge clock or negedge nrst)
begin
    if (!nrst)
    begin
        pre_reg <= {PRE_W{1'b0}};
        ext_prev_reg <= 1'b0;
    end
    else if (ce)
    begin
        pre_reg <= pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};
        ext_prev_reg <= ext_level;
    end
end

always @*
begin
    case (clock_select_field)
        `TMR8_CS_STOP: timer_tick = 1'b0;
        `TMR8_CS_DIV1: timer_tick = 1'b1;
        `TMR8_CS_DIV8: timer_tick = (pre_reg & `TMR8_MASK_DIV8) == `TMR8_MASK_DIV8;
        `TMR8_CS_DIV64: timer_tick = (pre_reg & `TMR8_MASK_DIV64) == `TMR8_MASK_DIV64;
        `TMR8_CS_DIV256: timer_tick = (pre_reg & `TMR8_MASK_DIV256) == `TMR8_MASK_DIV256;
        `TMR8_CS_DIV1024: timer_tick = (pre_reg & `TMR8_MASK_DIV1024) == `TMR8_MASK_DIV1024;
        `TMR8_CS_EXT_FALL: timer_tick = ext_prev_reg & ~ext_level;
        `TMR8_CS_EXT_RISE: timer_tick = ~ext_prev_reg & ext_level;
        default: timer_tick = 1'b0;
    endcase
end

endmodule // tmr8_tick_gen

// [testbench/tmr8_core_props.sv]
`include "tmr8_regs.vh"

// ================================================
// port checker for the timer core
module tmr8_core_props #(
    parameter ADR_W = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [ADR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_wdata,
    input wire logic [31:0] wb_rdata,
    input wire logic wb_ack,
    input wire logic global_irq_enable,
    input wire logic overflow_irq_taken,
    input wire logic compare_irq_taken,
    input wire logic external_count_pin,
    input wire logic overflow_irq,
    input wire logic compare_irq,
    input wire logic compare_output_pin,
    input wire logic compare_output_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    wire port_wr = wb_ack && wb_we && wb_sel[0] && wb_adr == `TMR8_ADR_PORT;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!nrst);
    sequence s_req;
        wb_cyc && wb_stb && !wb_ack && ce;
    endsequence
    sequence s_rd_unmapped;
        s_req ##0 (!wb_we && wb_adr > `TMR8_ADR_STATUS);
    endsequence
    a_ack_next: assert property (s_req |=> wb_ack)
        else $error("ack missing one cycle after request");
    a_ack_single: assert property (wb_ack && ce |=> !wb_ack)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(wb_ack) |-> $past(wb_stb))
        else $error("ack without request");
    a_rdata_high: assert property (wb_ack |-> wb_rdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_rdata_unmapped: assert property (s_rd_unmapped |=> wb_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_cirq_gie: assert property (!global_irq_enable && ce |=> !compare_irq)
        else $error("compare irq with global flag clear");
    a_oirq_gie: assert property (!global_irq_enable && ce |=> !overflow_irq)
        else $error("overflow irq with global flag clear");
    // the direction bit lands at the ack edge and reaches the pin register one edge later
    a_oe_cause: assert property (!$stable(compare_output_oe) |-> $past(port_wr, 2))
        else $error("pin direction changed without port write");
endmodule // tmr8_core_props

bind tmr8_core tmr8_core_props #(.ADR_W(ADR_W)) u_props (
    .clock(clock), .nrst(nrst), .ce(ce), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdata(wb_wdata),
    .wb_rdata(wb_rdata), .wb_ack(wb_ack), .global_irq_enable(global_irq_enable),
    .overflow_irq_taken(overflow_irq_taken), .compare_irq_taken(compare_irq_taken),
    .external_count_pin(external_count_pin), .overflow_irq(overflow_irq),
    .compare_irq(compare_irq), .compare_output_pin(compare_output_pin),
    .compare_output_oe(compare_output_oe)
);

// [testbench/tmr8_pin_model.sv]
// ================================================
// external count source: whole pulses on the count pin
module tmr8_pin_model (
    input wire logic clock,
    output logic ext_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial ext_pin = 1'b0;
    // high level held two cycles, low level three, so the sampler cannot miss it
    task automatic pulses(input int n);
        repeat (n)
        begin
            @(posedge clock) ext_pin <= 1'b1;
            repeat (2) @(posedge clock);
            ext_pin <= 1'b0;
            repeat (2) @(posedge clock);
        end
    endtask
endmodule // tmr8_pin_model

// [testbench/testbench.sv]
// ================================================
// self-checking bench for the timer core
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } tmr8_row_t;
    localparam int LIMIT = 20000;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_wdata = 32'h0;
    logic [31:0] wb_rdata;
    logic wb_ack;
    logic gie = 1'b0;
    logic ce = 1'b1;
    logic cmp_taken = 1'b0;
    logic ext_pin;
    logic ovf_irq;
    logic cmp_irq;
    logic pin;
    logic oe;
    logic [31:0] r;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    int div [4] = '{8, 64, 256, 1024};
    logic [7:0] ext_cs [3] = '{8'h00, 8'h06, 8'h07};
    logic [7:0] ext_n [3] = '{8'h00, 8'h05, 8'h05};
    tmr8_row_t rows [18] = '{
        '{1'b0, 8'h00, 8'h00, 8'h00}, '{1'b0, 8'h04, 8'h00, 8'h00},
        '{1'b0, 8'h08, 8'h00, 8'h00}, '{1'b0, 8'h0c, 8'h00, 8'h00},
        '{1'b0, 8'h10, 8'h00, 8'h00}, '{1'b0, 8'h14, 8'h00, 8'h00},
        '{1'b0, 8'h18, 8'h00, 8'h0d}, '{1'b1, 8'h04, 8'ha5, 8'ha5},
        '{1'b0, 8'h18, 8'h00, 8'h08}, '{1'b1, 8'h08, 8'h3c, 8'h3c},
        '{1'b1, 8'h10, 8'h03, 8'h03}, '{1'b1, 8'h00, 8'h98, 8'h18},
        '{1'b1, 8'h08, 8'h77, 8'h77}, '{1'b1, 8'h00, 8'h00, 8'h00},
        '{1'b0, 8'h08, 8'h00, 8'h3c}, '{1'b1, 8'h04, 8'hff, 8'hff},
        '{1'b0, 8'h18, 8'h00, 8'h0a}, '{1'b1, 8'h1c, 8'hff, 8'h00}
    };

    tmr8_core #(.ADR_W(8)) dut (
        .clock(clock), .nrst(nrst), .ce(ce), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(4'h1), .wb_wdata(wb_wdata),
        .wb_rdata(wb_rdata), .wb_ack(wb_ack), .global_irq_enable(gie),
        .overflow_irq_taken(1'b0), .compare_irq_taken(cmp_taken),
        .external_count_pin(ext_pin), .overflow_irq(ovf_irq), .compare_irq(cmp_irq),
        .compare_output_pin(pin), .compare_output_oe(oe)
    );
    tmr8_pin_model pin_m (.clock(clock), .ext_pin(ext_pin));

    initial
    begin
        forever #10 clock = ~clock;
    end

    task automatic print_verdict();
        if (n_fail == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request held until ack is sampled, released at that same edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdata <= {24'h0, d};
        @(posedge clock);
        while (wb_ack !== 1'b1) @(posedge clock);
        r = wb_rdata;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(r, {24'h0, e});
    endtask

    task automatic rd_rng(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        bus(1'b0, a, 8'h00);
        chk({31'h0, r[7:0] >= lo && r[7:0] <= hi}, 32'h1);
    endtask

    task automatic pin_chk(input logic p, input logic o);
        repeat (2) @(posedge clock);
        chk({30'h0, oe, pin}, {30'h0, o, p});
    endtask

    task automatic run(input logic [7:0] c, input int n);
        wr(8'h00, c);
        repeat (n) @(posedge clock);
        wr(8'h00, 8'h00);
    endtask

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            n_fail++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        foreach (rows[i])
        begin
            if (rows[i].w)
                wr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e);
        end
        // compare match, wrap overflow and interrupt gating
        wr(8'h08, 8'h05);
        wr(8'h04, 8'h04);
        wr(8'h0c, 8'h03);
        wr(8'h10, 8'h03);
        gie <= 1'b1;
        run(8'h01, 300);
        rdc(8'h0c, 8'h03);
        chk({30'h0, ovf_irq, cmp_irq}, 32'h3);
        gie <= 1'b0;
        repeat (2) @(posedge clock);
        chk({30'h0, ovf_irq, cmp_irq}, 32'h0);
        gie <= 1'b1;
        repeat (2) @(posedge clock);
        cmp_taken <= 1'b1;
        @(posedge clock);
        cmp_taken <= 1'b0;
        repeat (3) @(posedge clock);
        chk({30'h0, ovf_irq, cmp_irq}, 32'h2);
        rdc(8'h0c, 8'h01);
        wr(8'h0c, 8'h01);
        rdc(8'h0c, 8'h00);
        // a counter write equal to compare hides the first match
        wr(8'h08, 8'h10);
        wr(8'h04, 8'h10);
        run(8'h01, 0);
        rdc(8'h0c, 8'h00);
        // forced compare and pin override
        wr(8'h04, 8'h33);
        wr(8'h00, 8'h60);
        wr(8'h00, 8'he0);
        pin_chk(1'b1, 1'b0);
        rdc(8'h0c, 8'h00);
        rdc(8'h04, 8'h33);
        wr(8'h00, 8'h20);
        wr(8'h00, 8'ha0);
        pin_chk(1'b0, 1'b0);
        wr(8'h00, 8'he0);
        wr(8'h00, 8'h58);
        wr(8'h00, 8'hd8);
        pin_chk(1'b1, 1'b0);
        wr(8'h14, 8'h02);
        pin_chk(1'b1, 1'b1);
        wr(8'h00, 8'h00);
        pin_chk(1'b0, 1'b1);
        // external edges, and a stopped timer ignoring them
        for (int i = 0; i < 3; i++)
        begin
            wr(8'h04, 8'h00);
            wr(8'h00, ext_cs[i]);
            pin_m.pulses(5);
            repeat (4) @(posedge clock);
            wr(8'h00, 8'h00);
            rdc(8'h04, ext_n[i]);
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h04, 8'h00);
            run(8'(i + 2), 3 * div[i]);
            rd_rng(8'h04, 8'h03, 8'h04);
        end
        wr(8'h00, 8'h01);
        wr(8'h04, 8'h40);
        wr(8'h00, 8'h00);
        rd_rng(8'h04, 8'h40, 8'h45);
        wr(8'h00, 8'h18);
        wr(8'h08, 8'h99);
        run(8'h19, 300);
        rdc(8'h08, 8'h99);
        wr(8'h08, 8'h20);
        wr(8'h04, 8'h00);
        run(8'h31, 300);
        rd_rng(8'h04, 8'h00, 8'h20);
        // dual-slope count turns at max: 303 ticks from zero end at 0xcf, counting down
        wr(8'h04, 8'h00);
        run(8'h09, 300);
        rdc(8'h04, 8'hcf);
        rdc(8'h18, 8'h00);
        // clock enable low freezes the running counter; only the three ticks after it count
        wr(8'h04, 8'h00);
        wr(8'h00, 8'h01);
        ce <= 1'b0;
        repeat (20) @(posedge clock);
        ce <= 1'b1;
        wr(8'h00, 8'h00);
        rdc(8'h04, 8'h03);
        // output state set before reset, so the clear is visible
        wr(8'h14, 8'h02);
        wr(8'h00, 8'h60);
        wr(8'h00, 8'he0);
        pin_chk(1'b1, 1'b1);
        // reset in mid-run clears the output state
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        chk({29'h0, wb_ack, oe, pin}, 32'h0);
        nrst <= 1'b1;
        wr(8'h14, 8'h01);
        wr(8'h00, 8'h60);
        pin_chk(1'b0, 1'b0);
        print_verdict();
    end
endmodule // testbench
